// *** usf_cfg.svh ***
`ifndef USF_CFG_SVH
`define USF_CFG_SVH
// Function
// - fifo error summary bit stays zero while fifos are disabled
// - fifo mode: summary bit high while any queued character has an error
// - transmitter idle bit high when holding stage and shifter are empty
// - non-fifo: holding empty sets on move to shifter, clears on write
// - fifo mode: holding empty sets when tx fifo empties, clears on write
// - holding empty with its enable raises the interrupt request
// - break bit sets when the line stays low a whole character time
// - break bit clears when the status register is read
// - fifo mode: one all-zero character is queued per break
// - after break, reception waits for half a bit time of high line
// - error bits travel with each character, shown when it is at head
// - any of bits one to four with its enable raises the interrupt
// - stop-bit error bit sets when the sampled stop bit is low, except on a break
// - stop-bit error bit clears when the status register is read
// - after a stop-bit error the bad stop bit is taken as a start bit
// - parity mismatch bit sets on a bad parity, clears on status read
// - non-fifo: new character overwrites unread one and flags overrun
// - fifo mode: overrun only when full; the new character is dropped
// - overrun bit sets at once and clears on status read
// - data ready sets on a stored character, clears when all are read
// - loopback holds the line high and feeds the shifter to the receiver

// ----------------------------------------
// register indexes, byte address is four times the index
// ----------------------------------------
`define USF_IDX_DATA 3'h0
`define USF_IDX_IER 3'h1
`define USF_IDX_FCR 3'h2
`define USF_IDX_LCR 3'h3
`define USF_IDX_MCR 3'h4
`define USF_IDX_STAT 3'h5
`define USF_STAT_RESET 8'h60

// ----------------------------------------
// field positions
// ----------------------------------------
`define USF_IER_RDA 0
`define USF_IER_HOLD 1
`define USF_IER_RLS 2
`define USF_FCR_EN 0
`define USF_FCR_RXCLR 1
`define USF_FCR_TXCLR 2
`define USF_LCR_STB 2
`define USF_LCR_PEN 3
`define USF_LCR_EPS 4
`define USF_MCR_LOOP 4

// ----------------------------------------
// sample tick counts, sixteen ticks per bit
// ----------------------------------------
`define USF_MID_TICK 4'h7
`define USF_LAST_TICK 4'hf
`define USF_HALF_BIT 4'h7
`endif

// *** usf_pkg.sv ***
package usf_pkg;
    typedef enum logic [2:0] {
        R_IDLE, R_START, R_DATA, R_PAR, R_STOP, R_BRK
    } usf_rx_t;
    typedef enum logic [2:0] {
        T_IDLE, T_START, T_DATA, T_PAR, T_STOP
    } usf_tx_t;
endpackage : usf_pkg

// *** usf_core.sv ***
// Chosen here: register access over AHB-Lite.
`include "usf_cfg.svh"
module usf_core #(
    parameter int DEPTH = 16,
    parameter int TICK_DIV = 16
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic rxd_pin,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic txd_pin,
    output logic irq
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;

    // refuse depths the pointer logic cannot serve
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || TICK_DIV < 1
        || TICK_DIV > 65536) begin : g_chk
        $error("usf_core: bad DEPTH or TICK_DIV");
    end

    // ----------------------------------------
    // bus slave
    // ----------------------------------------
    logic ph_v;
    logic ph_w;
    logic ph_ok;
    logic [2:0] ph_idx;
    logic [2:0] ier;
    logic fcr_en;
    logic [4:0] lcr;
    logic loop;
    wire acc = hsel & htrans[1] & hready;
    wire wr_ok = ph_v & ph_w & ph_ok;
    wire rd_ok = ph_v & ~ph_w & ph_ok;
    wire wr_hold = wr_ok & (ph_idx == `USF_IDX_DATA);
    wire wr_ier = wr_ok & (ph_idx == `USF_IDX_IER);
    wire wr_fcr = wr_ok & (ph_idx == `USF_IDX_FCR);
    wire wr_lcr = wr_ok & (ph_idx == `USF_IDX_LCR);
    wire wr_mcr = wr_ok & (ph_idx == `USF_IDX_MCR);
    wire rd_rbr = rd_ok & (ph_idx == `USF_IDX_DATA);
    wire rd_stat = rd_ok & (ph_idx == `USF_IDX_STAT);
    wire fclr = wr_fcr & (hwdata[`USF_FCR_EN] != fcr_en);
    wire rx_clr = fclr | (wr_fcr & hwdata[`USF_FCR_RXCLR]);
    wire tx_clr = fclr | (wr_fcr & hwdata[`USF_FCR_TXCLR]);

    // address phase capture; reads take one wait state
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ph_v <= 1'b0;
            ph_w <= 1'b0;
            ph_ok <= 1'b0;
            ph_idx <= 3'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            ph_v <= acc;
            ph_w <= hwrite;
            ph_ok <= (haddr[31:5] == 27'h0) && (haddr[1:0] == 2'h0);
            ph_idx <= haddr[4:2];
            hreadyout <= ~(acc & ~hwrite);
            hresp <= 1'b0;
        end
    end

    // control registers written by software
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ier <= 3'h0;
            fcr_en <= 1'b0;
            lcr <= 5'h03;
            loop <= 1'b0;
        end else begin
            if (wr_ier) ier <= hwdata[2:0];
            if (wr_fcr) fcr_en <= hwdata[`USF_FCR_EN];
            if (wr_lcr) lcr <= hwdata[4:0];
            if (wr_mcr) loop <= hwdata[`USF_MCR_LOOP];
        end
    end

    // ----------------------------------------
    // sample tick and line input
    // ----------------------------------------
    logic [15:0] tdiv;
    logic rs1;
    logic rs2;
    logic tx_o;
    wire tick = (tdiv == 16'(TICK_DIV - 1));
    wire rx_in = loop ? tx_o : rs2;
    wire pen = lcr[`USF_LCR_PEN];
    wire [2:0] nb_last = {1'b1, lcr[1:0]};

    // divider and two-stage line synchroniser
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tdiv <= 16'h0;
            rs1 <= 1'b1;
            rs2 <= 1'b1;
            txd_pin <= 1'b1;
        end else begin
            tdiv <= tick ? 16'h0 : tdiv + 16'h1;
            rs1 <= rxd_pin;
            rs2 <= rs1;
            txd_pin <= loop | tx_o;
        end
    end

    // ----------------------------------------
    // receiver
    // ----------------------------------------
    usf_pkg::usf_rx_t rst;
    logic [3:0] smp;
    logic [2:0] bitn;
    logic [7:0] sh;
    logic pbit;
    logic allz;
    wire stop_smp = (rst == usf_pkg::R_STOP) & tick & (smp == `USF_LAST_TICK);
    wire [7:0] rdat = sh >> (2'h3 - lcr[1:0]);
    wire perr = pen & ((^{rdat, pbit}) ^ ~lcr[`USF_LCR_EPS]);
    wire brk = stop_smp & allz & ~rx_in;
    wire [10:0] word = brk ? 11'h400
        : {1'b0, ~rx_in, perr, rdat};

    // frame sampling state machine
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst <= usf_pkg::R_IDLE;
            smp <= 4'h0;
            bitn <= 3'h0;
            sh <= 8'h0;
            pbit <= 1'b0;
            allz <= 1'b0;
        end else begin
            unique case (rst)
                usf_pkg::R_IDLE: begin
                    smp <= 4'h0;
                    if (!rx_in) rst <= usf_pkg::R_START;
                end
                usf_pkg::R_START: if (tick) begin
                    smp <= smp + 4'h1;
                    if (smp == `USF_MID_TICK) begin
                        smp <= 4'h0;
                        bitn <= 3'h0;
                        allz <= 1'b1;
                        rst <= rx_in ? usf_pkg::R_IDLE : usf_pkg::R_DATA;
                    end
                end
                usf_pkg::R_DATA: if (tick) begin
                    smp <= smp + 4'h1;
                    if (smp == `USF_LAST_TICK) begin
                        sh <= {rx_in, sh[7:1]};
                        allz <= allz & ~rx_in;
                        bitn <= bitn + 3'h1;
                        if (bitn == nb_last)
                            rst <= pen ? usf_pkg::R_PAR : usf_pkg::R_STOP;
                    end
                end
                usf_pkg::R_PAR: if (tick) begin
                    smp <= smp + 4'h1;
                    if (smp == `USF_LAST_TICK) begin
                        pbit <= rx_in;
                        allz <= allz & ~rx_in;
                        rst <= usf_pkg::R_STOP;
                    end
                end
                usf_pkg::R_STOP: if (tick) begin
                    smp <= smp + 4'h1;
                    if (smp == `USF_LAST_TICK) begin
                        smp <= 4'h0;
                        if (brk) rst <= usf_pkg::R_BRK;
                        else if (!rx_in) rst <= usf_pkg::R_START;
                        else rst <= usf_pkg::R_IDLE;
                    end
                end
                usf_pkg::R_BRK: if (tick) begin
                    smp <= rx_in ? smp + 4'h1 : 4'h0;
                    if (rx_in && smp == `USF_HALF_BIT)
                        rst <= usf_pkg::R_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // receive fifo, depth one when fifos are off
    // ----------------------------------------
    logic [10:0] rmem [DEPTH];
    logic [AW-1:0] rwp;
    logic [AW-1:0] rrp;
    logic [CW-1:0] rcnt;
    logic [CW-1:0] ecnt;
    logic hn;
    wire [CW-1:0] cap = fcr_en ? CW'(DEPTH) : CW'(1);
    wire [10:0] head = rmem[rrp];
    wire rpop = rd_rbr & (rcnt != '0);
    wire rfull = (rcnt >= cap);
    wire rpush = stop_smp & (~rfull | rpop);
    wire ovr = stop_smp & rfull & ~rpop;
    wire ovw = ovr & ~fcr_en;
    wire werr = |word[10:8];
    wire herr = |head[10:8];
    wire [CW-1:0] einc = CW'((rpush | ovw) & werr);
    wire [CW-1:0] edec = CW'((rpop | ovw) & herr);
    wire next_hn = (rpop & (rcnt > CW'(1)))
        | (rpush & ((rcnt == '0) | rpop)) | ovw;

    // storage write, overwrite of the unread character
    always_ff @(posedge clk) begin
        if (rpush) rmem[rwp] <= word;
        else if (ovw) rmem[rrp] <= word;
    end

    // pointers, fill count and error count
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rwp <= '0;
            rrp <= '0;
            rcnt <= '0;
            ecnt <= '0;
            hn <= 1'b0;
        end else if (rx_clr) begin
            rwp <= '0;
            rrp <= '0;
            rcnt <= '0;
            ecnt <= '0;
            hn <= 1'b0;
        end else begin
            if (rpush) rwp <= rwp + 1'b1;
            if (rpop) rrp <= rrp + 1'b1;
            rcnt <= rcnt + CW'(rpush) - CW'(rpop);
            ecnt <= ecnt + einc - edec;
            hn <= next_hn;
        end
    end

    // ----------------------------------------
    // transmit fifo and shifter
    // ----------------------------------------
    usf_pkg::usf_tx_t tst;
    logic [7:0] tmem [DEPTH];
    logic [AW-1:0] twp;
    logic [AW-1:0] trp;
    logic [CW-1:0] tcnt;
    logic [3:0] tt;
    logic [2:0] tb;
    logic [7:0] tsh;
    logic tpar;
    logic tstp;
    wire twr = wr_hold & (tcnt < cap);
    wire tpop = (tst == usf_pkg::T_IDLE) & (tcnt != '0);
    wire [7:0] tdat = tmem[trp] & (8'hff >> (2'h3 - lcr[1:0]));
    wire [CW-1:0] next_tcnt = tcnt + CW'(twr) - CW'(tpop);
    wire tlast = tick & (tt == `USF_LAST_TICK);

    // holding storage
    always_ff @(posedge clk) begin
        if (twr) tmem[twp] <= hwdata[7:0];
    end

    // holding pointers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            twp <= '0;
            trp <= '0;
            tcnt <= '0;
        end else if (tx_clr) begin
            twp <= '0;
            trp <= '0;
            tcnt <= '0;
        end else begin
            if (twr) twp <= twp + 1'b1;
            if (tpop) trp <= trp + 1'b1;
            tcnt <= next_tcnt;
        end
    end

    // frame sending state machine
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tst <= usf_pkg::T_IDLE;
            tt <= 4'h0;
            tb <= 3'h0;
            tsh <= 8'h0;
            tpar <= 1'b0;
            tstp <= 1'b0;
            tx_o <= 1'b1;
        end else begin
            if (tick) tt <= tt + 4'h1;
            unique case (tst)
                usf_pkg::T_IDLE: begin
                    tx_o <= 1'b1;
                    tt <= 4'h0;
                    if (tpop) begin
                        tsh <= tdat;
                        tpar <= (^tdat) ^ ~lcr[`USF_LCR_EPS];
                        tst <= usf_pkg::T_START;
                    end
                end
                usf_pkg::T_START: begin
                    tx_o <= 1'b0;
                    tb <= 3'h0;
                    if (tlast) tst <= usf_pkg::T_DATA;
                end
                usf_pkg::T_DATA: begin
                    tx_o <= tsh[0];
                    tstp <= lcr[`USF_LCR_STB];
                    if (tlast) begin
                        tsh <= tsh >> 1;
                        tb <= tb + 3'h1;
                        if (tb == nb_last)
                            tst <= pen ? usf_pkg::T_PAR : usf_pkg::T_STOP;
                    end
                end
                usf_pkg::T_PAR: begin
                    tx_o <= tpar;
                    if (tlast) tst <= usf_pkg::T_STOP;
                end
                usf_pkg::T_STOP: begin
                    tx_o <= 1'b1;
                    if (tlast) begin
                        if (tstp) tstp <= 1'b0;
                        else tst <= usf_pkg::T_IDLE;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // line status flags
    // ----------------------------------------
    logic hemp;
    logic temt;
    logic oe;
    logic pf;
    logic sf;
    logic bk;
    wire dr = (rcnt != '0);
    wire ferr = fcr_en & (ecnt != '0);
    wire [7:0] stat = {ferr, temt, hemp, bk, sf, pf, oe, dr};

    // sticky errors: a new event wins over the clearing read
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            oe <= 1'b0;
            pf <= 1'b0;
            sf <= 1'b0;
            bk <= 1'b0;
        end else begin
            oe <= ovr | (oe & ~rd_stat);
            pf <= (hn & head[8]) | (pf & ~rd_stat);
            sf <= (hn & head[9]) | (sf & ~rd_stat);
            bk <= (hn & head[10]) | (bk & ~rd_stat);
        end
    end

    // transmit emptiness flags
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hemp <= 1'(`USF_STAT_RESET >> 5);
            temt <= 1'(`USF_STAT_RESET >> 6);
        end else begin
            hemp <= (next_tcnt == '0);
            temt <= (tcnt == '0) & (tst == usf_pkg::T_IDLE)
                & ~twr;
        end
    end

    // ----------------------------------------
    // read data and interrupt request
    // ----------------------------------------
    wire [7:0] rd_val =
        (ph_idx == `USF_IDX_DATA) ? (dr ? head[7:0] : 8'h0) :
        (ph_idx == `USF_IDX_IER) ? {5'h0, ier} :
        (ph_idx == `USF_IDX_LCR) ? {3'h0, lcr} :
        (ph_idx == `USF_IDX_MCR) ? {3'h0, loop, 4'h0} :
        (ph_idx == `USF_IDX_STAT) ? stat : 8'h0;
    wire rls = oe | pf | sf | bk;

    // registered outputs
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hrdata <= 32'h0;
            irq <= 1'b0;
        end else begin
            hrdata <= {24'h0, rd_ok ? rd_val : 8'h0};
            irq <= (ier[`USF_IER_RDA] & dr)
                | (ier[`USF_IER_HOLD] & hemp)
                | (ier[`USF_IER_RLS] & rls);
        end
    end
endmodule : usf_core

// *** usf_core_asserts.sv ***
`include "usf_cfg.svh"
module usf_core_asserts (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic rxd_pin,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic txd_pin,
    input wire logic irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    logic ph_v, ph_w, ph_ok, fen, loop;
    logic [2:0] ph_idx, ier;
    // ----------------------------------------
    // bus phase tracking
    // ----------------------------------------
    wire taken = hsel && htrans[1] && hready;
    wire good = haddr[31:5] == 27'h0 && haddr[1:0] == 2'h0;
    wire done = ph_v && hreadyout;
    wire rd_out = done && !ph_w;
    wire st_out = rd_out && ph_ok && ph_idx == `USF_IDX_STAT;
    wire wr_go = done && ph_w && ph_ok;
    // address phase held until its data phase ends
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ph_v <= 1'b0;
            ph_w <= 1'b0;
            ph_ok <= 1'b0;
            ph_idx <= 3'h0;
        end else if (taken) begin
            ph_v <= 1'b1;
            ph_w <= hwrite;
            ph_ok <= good;
            ph_idx <= haddr[4:2];
        end else if (hready) begin
            ph_v <= 1'b0;
        end
    end
    // shadow of enables, fifo mode and loopback
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ier <= 3'h0;
            fen <= 1'b0;
            loop <= 1'b0;
        end else if (wr_go) begin
            if (ph_idx == `USF_IDX_IER) ier <= hwdata[2:0];
            if (ph_idx == `USF_IDX_FCR) fen <= hwdata[`USF_FCR_EN];
            if (ph_idx == `USF_IDX_MCR) loop <= hwdata[`USF_MCR_LOOP];
        end
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    property p_rd_wait;
        taken && !hwrite |=> !hreadyout ##1 hreadyout;
    endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
    property p_wr_fast;
        taken && hwrite |=> hreadyout;
    endproperty
    a_wr_fast: assert property (p_wr_fast) else $error("write stalled");
    property p_hi_zero;
        hreadyout |-> hrdata[31:8] == 24'h0;
    endproperty
    a_hi_zero: assert property (p_hi_zero) else $error("upper data set");
    property p_okay;
        hresp == 1'b0;
    endproperty
    a_okay: assert property (p_okay) else $error("response not okay");
    property p_fifo_err_off;
        st_out && !fen |-> !hrdata[7];
    endproperty
    a_fifo_err_off: assert property (p_fifo_err_off)
        else $error("fifo error bit set in plain mode");
    property p_idle_room;
        st_out && hrdata[6] |-> hrdata[5];
    endproperty
    a_idle_room: assert property (p_idle_room)
        else $error("idle without holding empty");
    property p_idle_line;
        st_out && hrdata[6] |-> txd_pin;
    endproperty
    a_idle_line: assert property (p_idle_line)
        else $error("idle while line busy");
    property p_irq_quiet;
        ier == 3'h0 && $past(ier) == 3'h0 |-> !irq;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet)
        else $error("irq with no enable");
    property p_loop_high;
        loop && $past(loop) |-> txd_pin;
    endproperty
    a_loop_high: assert property (p_loop_high)
        else $error("line driven in loopback");
    property p_unmapped;
        rd_out && (!ph_ok || ph_idx > 3'h5) |-> hrdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
endmodule : usf_core_asserts

// *** usf_partner.sv ***
module usf_partner #(
    parameter int BIT = 16
) (
    input wire logic clk,
    input wire logic txd,
    output logic rxd
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got;
    int got_n;
    // ----------------------------------------
    // line driver, marking level when idle
    // ----------------------------------------
    initial begin
        rxd = 1'b1;
        got = 8'h00;
        got_n = 0;
    end
    task automatic hold(input logic v, input int n);
        rxd <= v;
        repeat (n) @(posedge clk);
    endtask : hold
    // one frame lsb first; stop_lo clocks of low stop make a bad stop
    task automatic send(input logic [7:0] b, input logic pen,
                        input logic pb, input int stop_lo);
        hold(1'b0, BIT);
        for (int i = 0; i < 8; i++) begin
            hold(b[i], BIT);
        end
        if (pen) begin
            hold(pb, BIT);
        end
        if (stop_lo > 0) begin
            hold(1'b0, stop_lo);
        end
        hold(1'b1, BIT);
    endtask : send
    // long spacing, then marking before any new start
    task automatic brk(input int n);
        hold(1'b0, n);
        hold(1'b1, BIT);
    endtask : brk
    // receiver of the device's transmit line, eight data bits
    initial begin
        forever begin
            @(negedge txd);
            repeat (BIT + BIT / 2) @(posedge clk);
            for (int i = 0; i < 8; i++) begin
                got[i] = txd;
                repeat (BIT) @(posedge clk);
            end
            got_n++;
        end
    end
endmodule : usf_partner

// *** uart_receive_transmit_status_flags_tb.sv ***
module uart_receive_transmit_status_flags_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BIT = 16;
    logic clk, rst_b, hsel, hwrite, hreadyout, hresp, txd_pin, irq, rxd_pin;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rv;
    logic [7:0] b1, b2, b3;
    int err_count, checks_done, n0;
    usf_core #(.DEPTH(2), .TICK_DIV(1)) i_usf_core (.clk(clk), .rst_b(rst_b),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .rxd_pin(rxd_pin), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .txd_pin(txd_pin), .irq(irq));
    usf_partner #(.BIT(BIT)) i_usf_partner (.clk(clk), .txd(txd_pin),
        .rxd(rxd_pin));
    // ----------------------------------------
    // expectation and reporting
    // ----------------------------------------
    function automatic logic [7:0] stat(input logic f7, bk, sf, pf, oe, dr);
        return {f7, 2'b11, bk, sf, pf, oe, dr};
    endfunction : stat
    task check(input string what, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task stop_test;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test
    // one single bus transfer, entered just after a rising edge
    task xfer(input logic w, input logic [2:0] idx, input logic [7:0] wd,
              output logic [31:0] rd);
        htrans <= 2'b10;
        haddr <= {27'h0, idx, 2'b00};
        hwrite <= w;
        @(posedge clk);
        while (!hreadyout) @(posedge clk);
        htrans <= 2'b00;
        hwdata <= {24'h0, wd};
        @(posedge clk);
        while (!hreadyout) @(posedge clk);
        rd = hrdata;
    endtask : xfer
    task wr(input logic [2:0] idx, input logic [7:0] d);
        xfer(1'b1, idx, d, rv);
    endtask : wr
    task rd(input logic [2:0] idx, input logic [7:0] exp, input string what);
        xfer(1'b0, idx, 8'h00, rv);
        check(what, rv, {24'h0, exp});
    endtask : rd
    task wait_tx(input int n);
        for (int k = 0; k < 4000 && i_usf_partner.got_n < n; k++) begin
            @(posedge clk);
        end
        check("tx count", i_usf_partner.got_n, n);
    endtask : wait_tx
    // ----------------------------------------
    // clock, watchdog
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        repeat (40000) @(posedge clk);
        err_count++;
        $display("watchdog expired");
        stop_test();
    end
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        {hsel, hwrite, htrans, haddr, hwdata, rst_b} = '0;
        hsize = 3'h2;
        err_count = 0;
        checks_done = 0;
        rv = $urandom(60);
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        hsel <= 1'b1;
        @(posedge clk);
        rd(5, 8'h60, "status at reset");
        b1 = $urandom;
        wr(1, b1 & 8'h07);
        rd(1, b1 & 8'h07, "enables");
        wr(1, 8'h00);
        wr(7, 8'hff);
        rd(7, 8'h00, "unmapped");
        $display("registers done");
        for (int i = 0; i < 3; i++) begin
            b1 = $urandom;
            i_usf_partner.send(b1, 1'b0, 1'b0, 0);
            rd(5, stat(0, 0, 0, 0, 0, 1), "ready");
            rd(0, b1, "rx data");
            rd(5, 8'h60, "drained");
        end
        b1 = 8'($urandom) | 8'h01; // nonzero, so a low stop is no break
        b2 = $urandom;
        i_usf_partner.send(b1, 1'b0, 1'b0, 0);
        i_usf_partner.send(b2, 1'b0, 1'b0, 0);
        wr(5, 8'h00);
        rd(1, 8'h00, "enables");
        rd(5, stat(0, 0, 0, 0, 1, 1), "overrun");
        rd(5, stat(0, 0, 0, 0, 0, 1), "overrun read");
        rd(0, b2, "overwritten");
        $display("receive done");
        wr(3, 8'h0b);
        wr(1, 8'h04);
        i_usf_partner.send(b1, 1'b1, ^b1, 0);
        check("irq line status", {31'h0, irq}, 32'h1);
        rd(5, stat(0, 0, 0, 1, 0, 1), "parity");
        repeat (2) @(posedge clk);
        check("irq after read", {31'h0, irq}, 32'h0);
        rd(5, stat(0, 0, 0, 0, 0, 1), "parity read");
        rd(0, b1, "parity data");
        wr(3, 8'h03);
        i_usf_partner.send(b1, 1'b0, 1'b0, 12);
        rd(5, stat(0, 0, 1, 0, 0, 1), "stop error");
        rd(5, stat(0, 0, 0, 0, 0, 1), "stop read");
        rd(0, b1, "stop data");
        i_usf_partner.send(b2, 1'b0, 1'b0, 0);
        rd(0, b2, "resync data");
        $display("errors done");
        wr(3, 8'h07);
        wr(1, 8'h02);
        repeat (3) @(posedge clk);
        check("irq holding", {31'h0, irq}, 32'h1);
        n0 = i_usf_partner.got_n;
        wr(0, b1);
        wr(0, b2);
        xfer(1'b0, 5, 8'h00, rv);
        check("tx busy", rv[6:5], 32'h0);
        wait_tx(n0 + 1);
        check("tx byte", i_usf_partner.got, b1);
        wait_tx(n0 + 2);
        check("tx byte", i_usf_partner.got, b2);
        repeat (2 * BIT) @(posedge clk);
        rd(5, 8'h60, "tx idle");
        wr(1, 8'h00);
        wr(2, 8'h01);
        b3 = $urandom;
        wr(0, b3);
        wr(0, b1);
        xfer(1'b0, 5, 8'h00, rv);
        check("fifo busy", rv[6:5], 32'h0);
        wait_tx(n0 + 4);
        check("fifo tx", i_usf_partner.got, b1);
        repeat (2 * BIT) @(posedge clk);
        rd(5, 8'h60, "fifo empty");
        $display("transmit done");
        i_usf_partner.send(b1, 1'b0, 1'b0, 0);
        i_usf_partner.send(b2, 1'b0, 1'b0, 0);
        i_usf_partner.send(b3, 1'b0, 1'b0, 0);
        rd(5, stat(0, 0, 0, 0, 1, 1), "fifo overrun");
        rd(0, b1, "fifo head");
        rd(0, b2, "fifo second");
        rd(5, 8'h60, "fifo drained");
        i_usf_partner.brk(30 * BIT);
        xfer(1'b0, 5, 8'h00, rv);
        check("break", rv & 8'hf7, stat(1, 1, 0, 0, 0, 1));
        xfer(1'b0, 5, 8'h00, rv);
        check("break read", rv & 8'hf7, stat(1, 0, 0, 0, 0, 1));
        rd(0, 8'h00, "break char");
        rd(5, 8'h60, "one break char");
        i_usf_partner.send(b3, 1'b0, 1'b0, 0);
        rd(0, b3, "after break");
        $display("fifo done");
        n0 = i_usf_partner.got_n;
        wr(4, 8'h10);
        wr(0, b2);
        repeat (12 * BIT) @(posedge clk);
        rd(5, stat(0, 0, 0, 0, 0, 1), "loop ready");
        rd(0, b2, "loop data");
        check("loop line", i_usf_partner.got_n, n0);
        wr(4, 8'h00);
        $display("loopback done");
        stop_test();
    end
endmodule : uart_receive_transmit_status_flags_tb
bind usf_core usf_core_asserts i_usf_core_asserts (.clk(clk), .rst_b(rst_b),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .rxd_pin(rxd_pin),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .txd_pin(txd_pin), .irq(irq));
